// *** hdl/tkrtc_counter.sv ***
`default_nettype none
module tkrtc_counter (
    input wire logic     clk,
    input wire logic     srst,
    tkrtc_time_if.counter tif
);
    import tkrtc_pkg::*;

    tkrtc_time_t cnt_reg;
    tkrtc_time_t cnt_next;

    function automatic tkrtc_byte_t bcd_inc(input tkrtc_byte_t v);
        if (v[3:0] == 4'h9)
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        else
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic tkrtc_byte_t month_len(input tkrtc_byte_t m, input tkrtc_byte_t y);
        logic leap;
        // bcd year divisible by 4: tens even with units 0/4/8, or tens odd with 2/6; 2000 is leap
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        case (m)
            8'h02: month_len = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
            default: month_len = 8'h31;
        endcase
    endfunction

    always_comb begin
        cnt_next = cnt_reg;
        if (tif.load) begin
            cnt_next = tif.load_val;
        end else if (tif.tick) begin
            cnt_next.sec = bcd_inc(cnt_reg.sec);
            if (cnt_reg.sec[6:0] >= 7'h59) begin
                cnt_next.sec = 8'h00;
                cnt_next.min = bcd_inc(cnt_reg.min);
                if (cnt_reg.min[6:0] >= 7'h59) begin
                    cnt_next.min = 8'h00;
                    cnt_next.hour = bcd_inc(cnt_reg.hour);
                    if (cnt_reg.hour[5:0] >= 6'h23) begin
                        cnt_next.hour = 8'h00;
                        cnt_next.day = (cnt_reg.day[2:0] >= 3'h7) ? 8'h01 : bcd_inc(cnt_reg.day);
                        cnt_next.date = bcd_inc(cnt_reg.date);
                        if (cnt_reg.date[5:0] >= month_len(cnt_reg.month, cnt_reg.year)) begin
                            cnt_next.date = 8'h01;
                            cnt_next.month = bcd_inc(cnt_reg.month);
                            if (cnt_reg.month[4:0] >= 5'h12) begin
                                cnt_next.month = 8'h01;
                                cnt_next.year = (cnt_reg.year == 8'h99) ? 8'h00 : bcd_inc(cnt_reg.year);
                            end
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst)
            cnt_reg <= '{year: 8'h00, month: 8'h01, date: 8'h01, day: 8'h01,
                         hour: 8'h00, min: 8'h00, sec: 8'h00};
        else
            cnt_reg <= cnt_next;
    end

    assign tif.now = cnt_reg;
endmodule
`default_nettype wire

// *** hdl/tkrtc_map.svh ***
`ifndef TKRTC_MAP_SVH
`define TKRTC_MAP_SVH
`define TKRTC_ADDR_W        13
`define TKRTC_ADDR_YEAR     13'h1FFF
`define TKRTC_ADDR_MONTH    13'h1FFE
`define TKRTC_ADDR_DATE     13'h1FFD
`define TKRTC_ADDR_DAY      13'h1FFC
`define TKRTC_ADDR_HOUR     13'h1FFB
`define TKRTC_ADDR_MIN      13'h1FFA
`define TKRTC_ADDR_SEC      13'h1FF9
`define TKRTC_ADDR_CTRL     13'h1FF8
`define TKRTC_CLK_HZ        25000000
`define TKRTC_TEST_HZ       512
`define TKRTC_BIT_LOAD      7
`define TKRTC_BIT_HOLD      6
`define TKRTC_BIT_HALT      7
`define TKRTC_BIT_TEST      6
`endif

// *** hdl/tkrtc_pkg.sv ***
`default_nettype none
package tkrtc_pkg;
    typedef logic [7:0] tkrtc_byte_t;
    typedef struct packed {
        tkrtc_byte_t year;
        tkrtc_byte_t month;
        tkrtc_byte_t date;
        tkrtc_byte_t day;
        tkrtc_byte_t hour;
        tkrtc_byte_t min;
        tkrtc_byte_t sec;
    } tkrtc_time_t;
endpackage
`default_nettype wire

// *** hdl/tkrtc_time_if.sv ***
`default_nettype none
interface tkrtc_time_if;
    import tkrtc_pkg::*;
    logic        tick;
    logic        load;
    tkrtc_time_t load_val;
    tkrtc_time_t now;
    modport counter (input tick, input load, input load_val, output now);
    modport owner   (output tick, output load, output load_val, input now);
endinterface
`default_nettype wire

// *** hdl/tkrtc_top.sv ***
// Overview of operation
// - 8K by 8 byte-wide RAM array, accessed one byte per cycle.
// - Clock registers sit at the eight highest addresses, same bus cycles.
// - All time fields kept in BCD, hours on 24-hour scale.
// - Month lengths and leap years corrected automatically through 2099.
// - Internal counters keep running while user copy is read or frozen.
// - Low supply ignores bus controls, blocks access, data lines released.
// - Hold bit 6 of control stops transfers into user registers.
// - During hold, user registers show time at the instant of hold.
// - Clearing hold refreshes all user time registers together within a second.
// - Load lock bit 7 of control halts updates so host writes time.
// - Clearing load lock copies user values into counters, resumes updating.
// - Crystal halt bit, seconds bit 7, stops the oscillator when 1.
// - Test toggle bit, day bit 6, toggles seconds LSB at 512 Hz.
// - Steady read of seconds in test mode shows toggle on data line 0.
// - Read when store strobe high and select low; drive only with output enable.
// - Write while store strobe and select active; host holds address stable.
// - Non-clock bits of clock locations act as plain RAM bits.
// - Open-drain power-fail flag held low while supply is low.
`include "tkrtc_map.svh"
`default_nettype none
module tkrtc_top #(
    parameter int CLK_HZ = `TKRTC_CLK_HZ
) (
    input  wire logic                     clk,
    input  wire logic                     srst,
    input  wire logic                     chip_select_n,
    input  wire logic                     chip_select_hi,
    input  wire logic                     output_enable_n,
    input  wire logic                     write_enable_n,
    input  wire logic [`TKRTC_ADDR_W-1:0] address_lines,
    input  wire logic [7:0]               data_bus_lines_in,
    output logic      [7:0]               data_bus_lines_out,
    output logic                          data_bus_lines_oe_n,
    input  wire logic                     supply_ok,
    output logic                          power_fail_flag_out,
    output logic                          power_fail_flag_oe_n
);
    import tkrtc_pkg::*;

    localparam int SEC_DIV  = CLK_HZ;
    localparam int TEST_DIV = CLK_HZ / (2 * `TKRTC_TEST_HZ);
    localparam int DEPTH    = 1 << `TKRTC_ADDR_W;

    if (CLK_HZ < 2 * `TKRTC_TEST_HZ) begin
        $error("clock too slow for test toggle");
    end

    // pins: two flops each before use
    logic [25:0] sync1_reg;
    logic [25:0] sync2_reg;
    logic [25:0] pins_in;
    assign pins_in = {supply_ok, chip_select_n, chip_select_hi, output_enable_n, write_enable_n,
                      address_lines, data_bus_lines_in};
    always_ff @(posedge clk) begin
        sync1_reg <= pins_in;
        sync2_reg <= sync1_reg;
    end

    logic                     s_ok;
    logic                     s_cs_n;
    logic                     s_cs_hi;
    logic                     s_oe_n;
    logic                     s_we_n;
    logic [`TKRTC_ADDR_W-1:0] s_addr;
    logic [7:0]               s_din;
    assign {s_ok, s_cs_n, s_cs_hi, s_oe_n, s_we_n, s_addr, s_din} = sync2_reg;

    logic sel;
    logic rd_act;
    logic wr_act;
    logic is_clk;
    assign sel    = s_ok && !s_cs_n && s_cs_hi;
    assign rd_act = sel && s_we_n && !s_oe_n;
    assign wr_act = sel && !s_we_n;
    assign is_clk = s_addr >= `TKRTC_ADDR_CTRL;

    // clock locations also live in the array; only clock bits are overlaid
    logic [7:0]               mem [0:DEPTH-1];
    logic [7:0]               mem_q;
    // address kept beside mem_q so overlay and ram bits come from one access
    logic [`TKRTC_ADDR_W-1:0] addr_q_reg;
    always_ff @(posedge clk) begin
        if (wr_act)
            mem[s_addr] <= s_din;
        mem_q      <= mem[s_addr];
        addr_q_reg <= s_addr;
    end

    // user copy and control state
    tkrtc_time_t user_reg,    user_next;
    logic        hold_reg,    hold_next;
    logic        lock_reg,    lock_next;
    logic        halt_reg,    halt_next;
    logic        test_reg,    test_next;
    logic        refresh_reg, refresh_next;
    logic        toggle_reg,  toggle_next;
    logic [31:0] sec_cnt_reg, sec_cnt_next;
    logic [31:0] tst_cnt_reg, tst_cnt_next;

    tkrtc_time_if tif ();
    tkrtc_counter u_counter (
        .clk  (clk),
        .srst (srst),
        .tif  (tif.counter)
    );

    logic wr_clk;
    assign wr_clk = wr_act && is_clk;

    always_comb begin
        user_next    = user_reg;
        hold_next    = hold_reg;
        lock_next    = lock_reg;
        halt_next    = halt_reg;
        test_next    = test_reg;
        refresh_next = refresh_reg;
        toggle_next  = toggle_reg;
        sec_cnt_next = sec_cnt_reg;
        tst_cnt_next = tst_cnt_reg;
        tif.tick     = 1'b0;
        tif.load     = 1'b0;
        tif.load_val = user_reg;

        if (!halt_reg) begin
            if (sec_cnt_reg >= 32'(SEC_DIV - 1)) begin
                sec_cnt_next = 32'h0000_0000;
                tif.tick     = 1'b1;
            end else begin
                sec_cnt_next = sec_cnt_reg + 32'h0000_0001;
            end
            if (tst_cnt_reg >= 32'(TEST_DIV - 1)) begin
                tst_cnt_next = 32'h0000_0000;
                toggle_next  = !toggle_reg;
            end else begin
                tst_cnt_next = tst_cnt_reg + 32'h0000_0001;
            end
        end

        // user copy follows counters each cycle unless held or locked
        if (!hold_reg && !lock_reg) begin
            user_next = tif.now;
        end

        if (wr_clk) begin
            case (s_addr)
                `TKRTC_ADDR_YEAR:  user_next.year  = s_din;
                `TKRTC_ADDR_MONTH: user_next.month = s_din;
                `TKRTC_ADDR_DATE:  user_next.date  = s_din;
                `TKRTC_ADDR_DAY: begin
                    user_next.day = s_din;
                    test_next     = s_din[`TKRTC_BIT_TEST];
                end
                `TKRTC_ADDR_HOUR:  user_next.hour  = s_din;
                `TKRTC_ADDR_MIN:   user_next.min   = s_din;
                `TKRTC_ADDR_SEC: begin
                    user_next.sec = s_din;
                    halt_next     = s_din[`TKRTC_BIT_HALT];
                end
                `TKRTC_ADDR_CTRL: begin
                    hold_next = s_din[`TKRTC_BIT_HOLD];
                    lock_next = s_din[`TKRTC_BIT_LOAD];
                    if (lock_reg && !s_din[`TKRTC_BIT_LOAD])
                        refresh_next = 1'b1;
                end
                default: ;
            endcase
        end

        // one cycle after unlock, push user values into the counters
        if (refresh_reg) begin
            tif.load     = 1'b1;
            refresh_next = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            user_reg    <= '0;
            hold_reg    <= 1'b0;
            lock_reg    <= 1'b0;
            halt_reg    <= 1'b0;
            test_reg    <= 1'b0;
            refresh_reg <= 1'b0;
            toggle_reg  <= 1'b0;
            sec_cnt_reg <= 32'h0000_0000;
            tst_cnt_reg <= 32'h0000_0000;
        end else begin
            user_reg    <= user_next;
            hold_reg    <= hold_next;
            lock_reg    <= lock_next;
            halt_reg    <= halt_next;
            test_reg    <= test_next;
            refresh_reg <= refresh_next;
            toggle_reg  <= toggle_next;
            sec_cnt_reg <= sec_cnt_next;
            tst_cnt_reg <= tst_cnt_next;
        end
    end

    // read mux: clock bits overlay array bits; unused bits read from RAM
    logic [7:0] rd_val;
    always_comb begin
        rd_val = mem_q;
        case (addr_q_reg)
            `TKRTC_ADDR_YEAR:  rd_val = user_reg.year;
            `TKRTC_ADDR_MONTH: rd_val = {mem_q[7:5], user_reg.month[4:0]};
            `TKRTC_ADDR_DATE:  rd_val = {mem_q[7:6], user_reg.date[5:0]};
            `TKRTC_ADDR_DAY:   rd_val = {mem_q[7], test_reg, mem_q[5:3], user_reg.day[2:0]};
            `TKRTC_ADDR_HOUR:  rd_val = {mem_q[7:6], user_reg.hour[5:0]};
            `TKRTC_ADDR_MIN:   rd_val = {mem_q[7], user_reg.min[6:0]};
            `TKRTC_ADDR_SEC:   rd_val = {halt_reg, user_reg.sec[6:1],
                                         (test_reg && !halt_reg) ? toggle_reg : user_reg.sec[0]};
            `TKRTC_ADDR_CTRL:  rd_val = {lock_reg, hold_reg, mem_q[5:0]};
            default: ;
        endcase
    end

    // drive waits one cycle for the array read, so the bus never shows a stale byte
    logic [7:0] dout_reg;
    logic       rd_q_reg;
    logic       drive_reg;
    always_ff @(posedge clk) begin
        if (srst) begin
            dout_reg  <= 8'h00;
            rd_q_reg  <= 1'b0;
            drive_reg <= 1'b0;
        end else begin
            dout_reg  <= rd_val;
            rd_q_reg  <= rd_act;
            drive_reg <= rd_q_reg;
        end
    end

    assign data_bus_lines_out   = dout_reg;
    assign data_bus_lines_oe_n  = !drive_reg;
    assign power_fail_flag_out  = 1'b0;
    assign power_fail_flag_oe_n = s_ok;
endmodule
`default_nettype wire

// *** tb/tkrtc_host_model.sv ***
`default_nettype none
module tkrtc_host_model (
    input  wire logic        clk,
    input  wire logic [7:0]  dout,
    input  wire logic        doe_n,
    output logic             cs_n,
    output logic             cs_hi,
    output logic             oe_n,
    output logic             we_n,
    output logic [12:0]      addr,
    output logic [7:0]       hd
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {cs_n, cs_hi, oe_n, we_n, addr, hd} = {4'b1011, 13'h0000, 8'h00};
    end
    // pins held well past the two-flop input sync
    task automatic wr(input logic [12:0] a, input logic [7:0] v);
        @(posedge clk);
        {cs_n, cs_hi, we_n, addr, hd} <= {3'b010, a, v};
        repeat (6) @(posedge clk);
        {cs_n, cs_hi, we_n} <= 3'b101;
        @(posedge clk);
        hd <= ~v;
        repeat (4) @(posedge clk);
    endtask
    // tg is -1 when the device never drove, else toggles of bit 0
    task automatic rd(input logic [12:0] a, input int n, output logic [7:0] d, output int tg);
        int i;
        logic p;
        tg = -1;
        d = 8'h00;
        @(posedge clk);
        {cs_n, cs_hi, oe_n, addr} <= {3'b010, a};
        for (i = 0; i < 10 && tg < 0; i++) begin
            @(negedge clk);
            if (doe_n === 1'b0) tg = 0;
        end
        d = dout;
        p = dout[0];
        if (tg >= 0) repeat (n) begin
            @(negedge clk);
            if (dout[0] !== p) tg++;
            p = dout[0];
        end
        @(posedge clk);
        {cs_n, cs_hi, oe_n} <= 3'b101;
        repeat (4) @(posedge clk);
    endtask
    // selects and output enable held at the given levels; seen goes high if the device drove
    task automatic probe(input logic [2:0] sel, input logic [12:0] a, output logic seen);
        seen = 1'b0;
        @(posedge clk);
        {cs_n, cs_hi, oe_n, addr} <= {sel, a};
        repeat (10) begin
            @(negedge clk);
            if (doe_n === 1'b0) seen = 1'b1;
        end
        @(posedge clk);
        {cs_n, cs_hi, oe_n} <= 3'b101;
        repeat (4) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// *** tb/tkrtc_top_monitor.sv ***
`default_nettype none
module tkrtc_top_monitor (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        chip_select_n,
    input wire logic        chip_select_hi,
    input wire logic        output_enable_n,
    input wire logic        write_enable_n,
    input wire logic [12:0] address_lines,
    input wire logic [7:0]  data_bus_lines_out,
    input wire logic        data_bus_lines_oe_n,
    input wire logic        supply_ok,
    input wire logic        power_fail_flag_out,
    input wire logic        power_fail_flag_oe_n
);
    wire logic rd = !chip_select_n && chip_select_hi && !output_enable_n && write_enable_n && supply_ok;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    chk_pf_level: assert property (power_fail_flag_out == 1'b0) else $error("flag level wrong");
    chk_pf_follow: assert property (!supply_ok [*3] |-> !power_fail_flag_oe_n)
        else $error("flag not pulled low");
    chk_drive_cause: assert property (!data_bus_lines_oe_n |-> $past(rd, 4))
        else $error("bus driven without read");
    chk_read_answer: assert property (rd [*5] |-> !data_bus_lines_oe_n)
        else $error("read not answered");
    chk_read_release: assert property (!rd [*5] |-> data_bus_lines_oe_n)
        else $error("bus not released");
    chk_write_quiet: assert property
        ((!chip_select_n && chip_select_hi && !write_enable_n) [*5] |-> data_bus_lines_oe_n)
        else $error("bus driven during write");
    chk_low_supply: assert property (!supply_ok [*6] |-> data_bus_lines_oe_n)
        else $error("driven at low supply");
    chk_ram_steady: assert property
        ((rd && address_lines < 13'h1FF8 && $stable(address_lines)) [*6] |-> $stable(data_bus_lines_out))
        else $error("ram data moved");
    chk_reset_quiet: assert property (disable iff (1'b0) $past(srst) |-> data_bus_lines_oe_n)
        else $error("driven in reset");
endmodule
bind tkrtc_top tkrtc_top_monitor u_tkrtc_top_monitor (
    .clk                  (clk),
    .srst                 (srst),
    .chip_select_n        (chip_select_n),
    .chip_select_hi       (chip_select_hi),
    .output_enable_n      (output_enable_n),
    .write_enable_n       (write_enable_n),
    .address_lines        (address_lines),
    .data_bus_lines_out   (data_bus_lines_out),
    .data_bus_lines_oe_n  (data_bus_lines_oe_n),
    .supply_ok            (supply_ok),
    .power_fail_flag_out  (power_fail_flag_out),
    .power_fail_flag_oe_n (power_fail_flag_oe_n)
);
`default_nettype wire

// *** tb/tkrtc_top_tb_top.sv ***
`default_nettype none
module tkrtc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import tkrtc_pkg::*;
    logic        clk, srst, cs_n, cs_hi, oe_n, we_n, sup, doe_n, pf_out, pf_oe_n, seen;
    logic [12:0] addr;
    tkrtc_byte_t hd, dout, d, held;
    int          err_total = 0, total_checks = 0, tg, i;
    wire logic [7:0] bus = doe_n ? hd : dout;
    // lock set first so clock rows read back as written
    logic [28:0] rows [11] = '{{13'h1FF8, 8'hA5, 8'hA5}, {13'h0000, 8'h5A, 8'h5A}, {13'h1FF7, 8'hC3, 8'hC3},
        {13'h1FFF, 8'h99, 8'h99}, {13'h1FFE, 8'h12, 8'h12}, {13'h1FFD, 8'h31, 8'h31}, {13'h1FFC, 8'h07, 8'h07},
        {13'h1FFB, 8'h23, 8'h23}, {13'h1FFA, 8'h59, 8'h59}, {13'h1FF9, 8'h59, 8'h59}, {13'h1234, 8'hFF, 8'hFF}};
    tkrtc_byte_t rolled [6] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
    tkrtc_top #(.CLK_HZ(2048)) u_tkrtc_top (.clk(clk), .srst(srst), .chip_select_n(cs_n),
        .chip_select_hi(cs_hi), .output_enable_n(oe_n), .write_enable_n(we_n), .address_lines(addr),
        .data_bus_lines_in(bus), .data_bus_lines_out(dout), .data_bus_lines_oe_n(doe_n), .supply_ok(sup),
        .power_fail_flag_out(pf_out), .power_fail_flag_oe_n(pf_oe_n));
    tkrtc_host_model u_tkrtc_host_model (.clk(clk), .dout(dout), .doe_n(doe_n), .cs_n(cs_n),
        .cs_hi(cs_hi), .oe_n(oe_n), .we_n(we_n), .addr(addr), .hd(hd));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic rd(input logic [12:0] a, input int n);
        u_tkrtc_host_model.rd(a, n, d, tg);
        if (tg < 0) begin
            chk(8'hFF, 8'h00);
            close_out();
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] v);
        u_tkrtc_host_model.wr(a, v);
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        srst = 1'b1;
        sup = 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        for (i = 0; i < 11; i++) begin
            wr(rows[i][28:16], rows[i][15:8]);
            rd(rows[i][28:16], 0);
            chk(d, rows[i][7:0]);
        end
        $display("table done");
        wr(13'h1FF8, 8'h00);
        repeat (2100) @(posedge clk);
        wr(13'h1FF8, 8'h40);
        for (i = 0; i < 6; i++) begin
            rd(13'h1FFF - 13'(i), 0);
            chk(d, rolled[i]);
        end
        rd(13'h1FF9, 0);
        held = d;
        chk(d & 8'hFE, 8'h00);
        $display("rollover done");
        repeat (2100) @(posedge clk);
        rd(13'h1FF9, 0);
        chk(d, held);
        wr(13'h1FF8, 8'h00);
        rd(13'h1FF9, 0);
        chk({7'h00, d > held}, 8'h01);
        $display("hold done");
        wr(13'h1FFC, 8'h41);
        rd(13'h1FF9, 64);
        chk({7'h00, tg > 24 && tg < 40}, 8'h01);
        wr(13'h1FF8, 8'h80);
        wr(13'h1FF9, 8'h80);
        wr(13'h1FF8, 8'h00);
        rd(13'h1FF9, 64);
        held = d;
        chk(tg[7:0], 8'h00);
        repeat (2100) @(posedge clk);
        rd(13'h1FF9, 0);
        chk(d, held);
        $display("oscillator done");
        // refused access must leave the ram byte untouched
        @(posedge clk) sup <= 1'b0;
        repeat (4) @(negedge clk);
        chk({7'h00, pf_oe_n}, 8'h00);
        chk({7'h00, pf_out}, 8'h00);
        wr(13'h0000, 8'h00);
        u_tkrtc_host_model.rd(13'h0000, 0, d, tg);
        chk({7'h00, tg < 0}, 8'h01);
        @(posedge clk) sup <= 1'b1;
        repeat (4) @(negedge clk);
        chk({7'h00, pf_oe_n}, 8'h01);
        rd(13'h0000, 0);
        chk(d, 8'h5A);
        $display("power fail done");
        // deselect by either select, and a read with output enable off, must leave the bus alone
        u_tkrtc_host_model.probe(3'b000, 13'h0000, seen);
        chk({7'h00, seen}, 8'h00);
        u_tkrtc_host_model.probe(3'b110, 13'h0000, seen);
        chk({7'h00, seen}, 8'h00);
        u_tkrtc_host_model.probe(3'b011, 13'h0000, seen);
        chk({7'h00, seen}, 8'h00);
        $display("select done");
        @(posedge clk) srst <= 1'b1;
        repeat (3) @(negedge clk);
        chk({7'h00, doe_n}, 8'h01);
        chk(dout, 8'h00);
        @(posedge clk) srst <= 1'b0;
        rd(13'h1234, 0);
        chk(d, 8'hFF);
        wr(13'h1FF8, 8'h40);
        rd(13'h1FFD, 0);
        chk(d, 8'h01);
        $display("reset done");
        close_out();
    end
endmodule
`default_nettype wire
